/* lbi_pkg.sv */
// shared types and constants of the local bus interface unit
package lbi_pkg;

	localparam int unsigned LBI_AW = 24;
	localparam int unsigned LBI_DW = 16;

	// synchronised pin inputs, bit positions
	localparam int unsigned IN_RST    = 0;
	localparam int unsigned IN_HOLD   = 1;
	localparam int unsigned IN_MASKABLE_IRQ   = 2;
	localparam int unsigned IN_NMI    = 3;
	localparam int unsigned IN_COPROC_OPERAND_REQUEST  = 4;
	localparam int unsigned IN_BUSY_N = 5;
	localparam int unsigned IN_ERR_N  = 6;
	localparam int unsigned IN_W      = 7;

	// register port
	localparam logic [1:0] REG_CTRL      = 2'h0;
	localparam logic [1:0] REG_STAT      = 2'h1;
	localparam int unsigned CTRL_IE_BIT   = 0;
	localparam int unsigned CTRL_LOCK_BIT = 1;
	localparam logic [7:0] CTRL_MASK     = 8'h03;
	localparam logic [7:0] CTRL_RST      = 8'h00;

	// timing counts and the non-maskable vector
	localparam int unsigned INIT_SYS_CYCLES = 50;
	localparam logic [2:0]  NMI_LOW_SYS_CYC = 3'h4;
	localparam logic [1:0]  MASKABLE_IRQ_MIN_PCYC   = 2'h2;
	localparam logic [1:0]  LOCK_SPAN       = 2'h2;
	localparam logic [1:0]  INTA_COUNT      = 2'h2;
	localparam logic [7:0]  NMI_VECTOR      = 8'h02;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_BUS_START = 3'b001,
		ST_BUS_WAIT  = 3'b011,
		ST_FLOAT     = 3'b010,
		ST_HELD      = 3'b110,
		ST_INIT      = 3'b100,
		ST_RESET     = 3'b101
	} lbi_state_t;

	typedef enum logic [2:0] {
		K_FETCH = 3'h0,
		K_MRD   = 3'h1,
		K_MWR   = 3'h2,
		K_IORD  = 3'h3,
		K_IOWR  = 3'h4,
		K_INTA  = 3'h5
	} lbi_kind_t;

	typedef struct packed {
		lbi_kind_t         kind;
		logic [LBI_AW-1:0] addr;
		logic              word;
		logic              lock;
		logic              exchange_instruction;
		logic              descriptor_access;
		logic [LBI_DW-1:0] wdata;
	} lbi_req_t;

	typedef struct packed {
		logic              done;
		logic              boot;
		logic [LBI_DW-1:0] rdata;
	} lbi_ans_t;

	typedef struct packed {
		logic       take;
		logic [7:0] vector;
	} lbi_int_t;

	typedef struct packed {
		logic [LBI_AW-1:0] addr;
		logic              addr_oe;
		logic              upper_byte_enable_n;
		logic              bus_status_hi_n;
		logic              bus_status_lo_n;
		logic              mem_io;
		logic              code_or_int_ack;
		logic              ctl_oe;
		logic              lock_n;
		logic              lock_oe;
		logic              coproc_operand_ack_n;
		logic              coproc_operand_ack_oe;
		logic              hold_grant;
		logic [LBI_DW-1:0] data;
		logic              data_oe;
	} lbi_pins_t;

	localparam lbi_pins_t PINS_RST = '{
		addr: 24'hff_ffff, addr_oe: 1'b1, upper_byte_enable_n: 1'b1,
		bus_status_hi_n: 1'b1, bus_status_lo_n: 1'b1, mem_io: 1'b0,
		code_or_int_ack: 1'b0, ctl_oe: 1'b1, lock_n: 1'b1, lock_oe: 1'b1,
		coproc_operand_ack_n: 1'b1, coproc_operand_ack_oe: 1'b1,
		hold_grant: 1'b0, data: 16'h0000, data_oe: 1'b0};

endpackage

/* lbi_bus_unit.sv */
// local bus interface unit: pin-level bus cycles, hold, lock, interrupts, coprocessor handshake
//
// Behaviour
// - processor clock is system clock halved; reset rising edge aligns the phase
// - i/o transfers drive address bits 23..16 low
// - address bit zero low whenever the lower byte lane is used
// - address floats and data bus stays floated while hold is granted
// - bus status outputs go low to mark each bus cycle start and type
// - code/ack output splits fetch from data read and int ack from i/o
// - lock asserted for prefix, exchange, int ack, descriptor; spans following cycle
// - lock floats as logic one while hold is granted
// - cycle extended until ready low; ready ignored while hold granted
// - on hold float drivers then grant; release grant and retake when hold falls
// - maskable request ignored when enable clear, else two ack cycles read vector
// - maskable request sampled each processor cycle, needs two cycles before end
// - non-maskable edge uses vector two, no ack cycles, ignores enable flag
// - operand request served by a transfer with operand ack low meanwhile
// - busy low stalls wait-type instructions; interrupts still taken while stalled
// - error low during wait-type instructions raises a coprocessor fault
// - reset pin clears internal logic; held over sixteen system clocks
// - during reset drive the documented pin levels and float data
// - reset rising edge makes a processor cycle end at second system clock
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

module lbi_bus_unit
	import lbi_pkg::*;
#(
	parameter logic [LBI_AW-1:0] P_BOOT_ADDR    = 24'h00_0000,
	parameter int unsigned       P_INIT_SYS_CYC = INIT_SYS_CYCLES
) (
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_ce,
	input  wire logic              i_reset,
	input  wire logic              i_ready_n,
	input  wire logic              i_hold,
	input  wire logic              i_maskable_irq,
	input  wire logic              i_nmi,
	input  wire logic              i_coproc_operand_request,
	input  wire logic              i_busy_n,
	input  wire logic              i_error_n,
	input  wire logic [LBI_DW-1:0] i_data,
	output lbi_pins_t              o_pins,
	input  wire logic              i_req_valid,
	input  lbi_req_t               i_req,
	input  lbi_req_t               i_pe_req,
	input  wire logic              i_insn_end,
	input  wire logic              i_coproc_wait_insn,
	output lbi_ans_t               o_ans,
	output lbi_int_t               o_int,
	output logic                   o_stall,
	output logic                   o_coproc_fault,
	input  wire logic [1:0]        i_reg_addr,
	input  wire logic [7:0]        i_reg_wdata,
	input  wire logic              i_reg_we,
	input  wire logic              i_reg_re,
	output logic [7:0]             o_reg_rdata
);

	if (P_INIT_SYS_CYC < 1 || P_INIT_SYS_CYC > 63) begin : g_chk
		$error("P_INIT_SYS_CYC must lie in 1..63");
	end

	localparam logic [5:0] INIT_LAST = 6'(P_INIT_SYS_CYC - 1);

	typedef struct packed {
		logic [IN_W-1:0] s1;
		logic [IN_W-1:0] s2;
		logic [IN_W-1:0] s3;
		logic [IN_W-1:0] f;
		logic            ph;
		logic            rst_prev;
		lbi_state_t      st;
		logic [5:0]      cnt;
		lbi_kind_t       kind;
		logic            word;
		logic            odd;
		logic            pe;
		logic            boot;
		logic            pe_armed;
		logic [1:0]      lock_left;
		logic [1:0]      inta_left;
		logic [1:0]      maskable_irq_cnt;
		logic [2:0]      nmi_low;
		logic            nmi_prev;
		logic            nmi_pend;
		logic [7:0]      ctrl;
		logic [7:0]      reg_rdata;
		lbi_pins_t       pins;
		lbi_ans_t        ans;
		lbi_int_t        maskable_irq;
		logic            stall;
		logic            fault;
	} lbi_core_t;

	lbi_core_t q;
	lbi_core_t n;

	function automatic lbi_pins_t launch(lbi_pins_t p, lbi_req_t r, logic lk, logic pe);
		lbi_pins_t o;
		logic      io;
		logic      wr;
		o  = p;
		io = (r.kind == K_IORD) || (r.kind == K_IOWR) || (r.kind == K_INTA);
		wr = (r.kind == K_MWR) || (r.kind == K_IOWR);
		o.addr = r.addr;
		if (io) begin
			o.addr[23:16] = 8'h00;
		end
		o.addr[0] = r.word ? 1'b0 : r.addr[0];
		o.upper_byte_enable_n = r.word ? 1'b0 : ~r.addr[0];
		o.bus_status_hi_n = (r.kind == K_INTA) ? 1'b0 : ~wr;
		o.bus_status_lo_n = (r.kind == K_INTA) ? 1'b0 : wr;
		o.mem_io = ~io;
		// memory side: fetch vs data; i/o side: port vs int ack
		o.code_or_int_ack = (r.kind == K_FETCH) || (r.kind == K_IORD)
			|| (r.kind == K_IOWR);
		o.data = r.word ? r.wdata : {r.wdata[7:0], r.wdata[7:0]};
		o.data_oe = wr;
		o.addr_oe = 1'b1;
		o.ctl_oe = 1'b1;
		o.lock_oe = 1'b1;
		o.lock_n = ~lk;
		o.coproc_operand_ack_oe = 1'b1;
		o.coproc_operand_ack_n = ~pe;
		return o;
	endfunction

	lbi_req_t boot_req;
	lbi_req_t inta_req;
	logic     rst_f;
	logic     take_pt;
	logic     nmi_set;
	logic     locked;
	lbi_req_t sel;
	logic     go;
	logic     go_pe;

	always_comb begin
		boot_req = '0;
		boot_req.kind = K_FETCH;
		boot_req.addr = P_BOOT_ADDR;
		boot_req.word = 1'b1;
		inta_req = '0;
		inta_req.kind = K_INTA;
		inta_req.lock = 1'b1;
		inta_req.word = 1'b1;
	end

	always_comb begin
		n = q;
		sel = i_req;
		go = 1'b0;
		go_pe = 1'b0;
		locked = 1'b0;
		n.ans.done = 1'b0;
		n.ans.boot = 1'b0;
		n.maskable_irq.take = 1'b0;
		n.reg_rdata = 8'h00;

		// three-stage pin sampling; a level counts once stages two and three agree
		n.s1 = {~i_error_n, ~i_busy_n, i_coproc_operand_request, i_nmi, i_maskable_irq,
			i_hold, i_reset};
		n.s1[IN_BUSY_N] = i_busy_n;
		n.s1[IN_ERR_N] = i_error_n;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.f = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));
		rst_f = q.f[IN_RST];
		n.rst_prev = rst_f;
		n.ph = ~q.ph;

		if (i_reg_we && i_reg_addr == REG_CTRL) begin
			n.ctrl = i_reg_wdata & CTRL_MASK;
		end
		if (i_reg_re) begin
			case (i_reg_addr)
				REG_CTRL: n.reg_rdata = q.ctrl;
				REG_STAT: n.reg_rdata = {q.st, q.pins.hold_grant, q.nmi_pend,
					(q.maskable_irq_cnt >= MASKABLE_IRQ_MIN_PCYC), q.stall, q.fault};
				default:  n.reg_rdata = 8'h00;
			endcase
		end

		n.stall = i_coproc_wait_insn & ~q.f[IN_BUSY_N];
		n.fault = i_coproc_wait_insn & ~q.f[IN_ERR_N];

		if (!q.ph) begin
			// sampled at the start of each processor cycle
			if (q.f[IN_MASKABLE_IRQ]) begin
				n.maskable_irq_cnt = (q.maskable_irq_cnt >= MASKABLE_IRQ_MIN_PCYC) ? q.maskable_irq_cnt : q.maskable_irq_cnt + 2'h1;
			end else begin
				n.maskable_irq_cnt = 2'h0;
			end
		end

		// edge only counts after a long enough low phase, filtering glitches
		nmi_set = q.f[IN_NMI] && !q.nmi_prev && q.nmi_low >= NMI_LOW_SYS_CYC;
		n.nmi_prev = q.f[IN_NMI];
		if (q.f[IN_NMI]) begin
			n.nmi_low = 3'h0;
		end else if (q.nmi_low < NMI_LOW_SYS_CYC) begin
			n.nmi_low = q.nmi_low + 3'h1;
		end

		take_pt = i_insn_end | q.stall;
		n.nmi_pend = nmi_set | q.nmi_pend;
		if (take_pt && q.nmi_pend) begin
			n.maskable_irq.take = 1'b1;
			n.maskable_irq.vector = NMI_VECTOR;
			n.nmi_pend = nmi_set;
		end else if (take_pt && q.ctrl[CTRL_IE_BIT] && q.maskable_irq_cnt >= MASKABLE_IRQ_MIN_PCYC
				&& q.inta_left == 2'h0) begin
			n.inta_left = INTA_COUNT;
			n.maskable_irq_cnt = 2'h0;
		end

		if (!q.f[IN_COPROC_OPERAND_REQUEST]) begin
			n.pe_armed = 1'b1;
		end

		if (rst_f) begin
			n.st = ST_RESET;
			n.pins = PINS_RST;
			n.cnt = 6'h00;
			n.inta_left = 2'h0;
			n.lock_left = 2'h0;
			n.maskable_irq_cnt = 2'h0;
			n.nmi_pend = 1'b0;
			n.pe = 1'b0;
			n.boot = 1'b0;
			n.ctrl = CTRL_RST;
			if (!q.rst_prev) begin
				n.ph = 1'b0;
			end
		end else begin
			case (q.st)
				ST_RESET: begin
					n.st = ST_INIT;
					n.cnt = 6'h00;
				end
				ST_INIT: begin
					// boot fetch waits for phase one so its status spans a processor cycle
					if (q.cnt != INIT_LAST) begin
						n.cnt = q.cnt + 6'h01;
					end else if (q.ph) begin
						sel = boot_req;
						go = 1'b1;
						n.boot = 1'b1;
					end
				end
				ST_IDLE: begin
					if (q.ph) begin
						if (q.f[IN_HOLD] && q.lock_left == 2'h0) begin
							n.st = ST_FLOAT;
							n.pins.addr_oe = 1'b0;
							n.pins.ctl_oe = 1'b0;
							n.pins.data_oe = 1'b0;
							n.pins.lock_n = 1'b1;
							n.pins.lock_oe = 1'b0;
							n.pins.coproc_operand_ack_n = 1'b1;
							n.pins.coproc_operand_ack_oe = 1'b0;
						end else if (q.inta_left != 2'h0) begin
							sel = inta_req;
							go = 1'b1;
						end else if (q.f[IN_COPROC_OPERAND_REQUEST] && q.pe_armed) begin
							sel = i_pe_req;
							go = 1'b1;
							go_pe = 1'b1;
							n.pe_armed = 1'b0;
						end else if (i_req_valid) begin
							go = 1'b1;
						end
					end
				end
				ST_BUS_START: begin
					if (q.ph) begin
						n.st = ST_BUS_WAIT;
						n.pins.bus_status_hi_n = 1'b1;
						n.pins.bus_status_lo_n = 1'b1;
					end
				end
				ST_BUS_WAIT: begin
					if (q.ph && !i_ready_n) begin
						n.st = ST_IDLE;
						n.pins.data_oe = 1'b0;
						n.pins.coproc_operand_ack_n = 1'b1;
						n.pe = 1'b0;
						n.boot = 1'b0;
						if (q.lock_left != 2'h0) begin
							n.lock_left = q.lock_left - 2'h1;
						end
						n.pins.lock_n = (n.lock_left == 2'h0);
						n.ans.rdata = q.word ? i_data
							: {8'h00, (q.odd ? i_data[15:8] : i_data[7:0])};
						if (q.kind == K_INTA) begin
							n.inta_left = q.inta_left - 2'h1;
							if (q.inta_left == 2'h1) begin
								n.maskable_irq.take = 1'b1;
								n.maskable_irq.vector = i_data[7:0];
							end
						end else if (q.boot) begin
							n.ans.boot = 1'b1;
						end else if (!q.pe) begin
							n.ans.done = 1'b1;
						end
					end
				end
				ST_FLOAT: begin
					if (q.ph) begin
						n.st = ST_HELD;
						n.pins.hold_grant = 1'b1;
					end
				end
				ST_HELD: begin
					// ready is not looked at here at all
					if (q.ph && !q.f[IN_HOLD]) begin
						n.st = ST_IDLE;
						n.pins.hold_grant = 1'b0;
						n.pins.addr_oe = 1'b1;
						n.pins.ctl_oe = 1'b1;
						n.pins.lock_oe = 1'b1;
						n.pins.coproc_operand_ack_oe = 1'b1;
					end
				end
				default: begin
					n.st = ST_IDLE;
				end
			endcase

			if (go) begin
				locked = sel.lock | sel.exchange_instruction | sel.descriptor_access
					| q.ctrl[CTRL_LOCK_BIT];
				if (locked && q.lock_left == 2'h0) begin
					n.lock_left = LOCK_SPAN;
				end
				// a software write in the same cycle wins, so a fresh lock request is kept
				if (!(i_reg_we && i_reg_addr == REG_CTRL)) begin
					n.ctrl[CTRL_LOCK_BIT] = 1'b0;
				end
				n.pins = launch(q.pins, sel, locked || q.lock_left != 2'h0, go_pe);
				n.st = ST_BUS_START;
				n.kind = sel.kind;
				n.word = sel.word;
				n.odd = sel.addr[0];
				n.pe = go_pe;
			end
		end

		if (!i_ce) begin
			n = q;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q <= '0;
			q.st <= ST_RESET;
			q.pins <= PINS_RST;
			q.ctrl <= CTRL_RST;
			q.f[IN_BUSY_N] <= 1'b1;
			q.f[IN_ERR_N] <= 1'b1;
			// idle levels in every stage, so no false busy or error follows reset
			q.s1[IN_BUSY_N] <= 1'b1;
			q.s1[IN_ERR_N] <= 1'b1;
			q.s2[IN_BUSY_N] <= 1'b1;
			q.s2[IN_ERR_N] <= 1'b1;
			q.s3[IN_BUSY_N] <= 1'b1;
			q.s3[IN_ERR_N] <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign o_pins = q.pins;
	assign o_ans = q.ans;
	assign o_int = q.maskable_irq;
	assign o_stall = q.stall;
	assign o_coproc_fault = q.fault;
	assign o_reg_rdata = q.reg_rdata;

endmodule

/* lbi_bus_unit_monitor.sv */
// pin-level assertion checker for the local bus interface unit
`timescale 1ns/1ps
module lbi_bus_unit_monitor
	import lbi_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	input  wire logic i_reset,
	input  wire logic i_ready_n,
	input  lbi_pins_t o_pins,
	input  lbi_ans_t  o_ans
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	logic idle_s;
	assign idle_s = o_pins.bus_status_hi_n & o_pins.bus_status_lo_n;

	property p_io_high;
		!idle_s && !o_pins.mem_io && o_pins.code_or_int_ack |-> o_pins.addr[23:16] == 8'h00;
	endproperty
	a_io_high: assert property (p_io_high) else $error("io cycle with upper address set");

	property p_lanes;
		!idle_s |-> !(o_pins.upper_byte_enable_n && o_pins.addr[0]);
	endproperty
	a_lanes: assert property (p_lanes) else $error("no byte lane selected");

	property p_float;
		o_pins.hold_grant |-> !o_pins.addr_oe && !o_pins.data_oe && !o_pins.ctl_oe;
	endproperty
	a_float: assert property (p_float) else $error("driver active under hold");

	property p_lock_one;
		o_pins.hold_grant |-> o_pins.lock_n && !o_pins.lock_oe;
	endproperty
	a_lock_one: assert property (p_lock_one) else $error("lock not floated high");

	property p_ack_one;
		o_pins.hold_grant |-> o_pins.coproc_operand_ack_n && !o_pins.coproc_operand_ack_oe;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("operand ack not floated high");

	property p_grant;
		$rose(o_pins.hold_grant) |-> !$past(o_pins.addr_oe) && !$past(o_pins.addr_oe, 2);
	endproperty
	a_grant: assert property (p_grant) else $error("grant before drivers floated");

	property p_status;
		$fell(idle_s) |=> !idle_s ##1 idle_s;
	endproperty
	a_status: assert property (p_status) else $error("status not low two cycles");

	property p_ready;
		o_ans.done |-> !$past(i_ready_n);
	endproperty
	a_ready: assert property (p_ready) else $error("cycle ended without ready");

	property p_inta;
		!(o_pins.bus_status_hi_n | o_pins.bus_status_lo_n)
			|-> !o_pins.mem_io && !o_pins.code_or_int_ack && o_pins.addr == 24'h00_0000;
	endproperty
	a_inta: assert property (p_inta) else $error("bad interrupt ack cycle type");

	property p_reset;
		i_reset [*8] |-> o_pins.addr == 24'hff_ffff && !o_pins.data_oe && !o_pins.hold_grant;
	endproperty
	a_reset: assert property (p_reset) else $error("pins not at reset levels");
endmodule

bind lbi_bus_unit lbi_bus_unit_monitor u_mon (
	.i_clk    (i_clk),
	.i_arst_n (i_arst_n),
	.i_reset  (i_reset),
	.i_ready_n(i_ready_n),
	.o_pins   (o_pins),
	.o_ans    (o_ans)
);

/* lbi_far_side.sv */
// far side model: memory and i/o answering bus cycles with ready and read data
`timescale 1ns/1ps
module lbi_far_side
	import lbi_pkg::*;
(
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	input  lbi_pins_t         i_pins,
	input  wire logic [3:0]   i_wait,
	output logic              o_ready_n,
	output logic [LBI_DW-1:0] o_data
);
	logic              act_q;
	logic              rl_q;
	logic              prev_q;
	logic [3:0]        cnt_q;
	logic [LBI_DW-1:0] last_q;
	logic              idle;
	logic [7:0]        a;
	assign idle = i_pins.bus_status_hi_n & i_pins.bus_status_lo_n;
	assign a = i_pins.addr[7:0];
	// open collector ready: pulled high unless terminating after the status phase
	assign o_ready_n = !(act_q && idle && cnt_q == 4'h0);
	// released lines show a changing pattern so a stale value never matches
	assign o_data = act_q ? {a ^ 8'ha5, a ^ 8'h3c} : ~last_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			act_q <= 1'b0;
			rl_q <= 1'b0;
			prev_q <= 1'b1;
			cnt_q <= 4'h0;
			last_q <= 16'h0000;
		end else begin
			prev_q <= idle;
			last_q <= o_data;
			if (prev_q && !idle) begin
				act_q <= 1'b1;
				cnt_q <= i_wait;
				rl_q <= 1'b0;
			end else if (act_q && idle && cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end else if (act_q && idle) begin
				rl_q <= 1'b1;
				act_q <= !rl_q;
			end
		end
	end
endmodule

/* lbi_bus_unit_bench.sv */
// self-checking bench for the local bus interface unit
`timescale 1ns/1ps
module lbi_bus_unit_bench
	import lbi_pkg::*;
;
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              rst_pin = 1'b0;
	logic              hold = 1'b0;
	logic              irq = 1'b0;
	logic              nmi = 1'b0;
	logic              preq = 1'b0;
	logic              busy_n = 1'b1;
	logic              err_n = 1'b1;
	logic              req_valid = 1'b0;
	logic              insn_end = 1'b0;
	logic              wait_insn = 1'b0;
	logic              reg_we = 1'b0;
	logic              reg_re = 1'b0;
	logic [1:0]        reg_addr = 2'h0;
	logic [7:0]        reg_wdata = 8'h00;
	logic [3:0]        wt = 4'h0;
	lbi_req_t          req = '0;
	lbi_req_t          pe_req = '0;
	logic [7:0]        reg_rdata;
	logic              ready_n;
	logic [LBI_DW-1:0] data;
	lbi_pins_t         pins;
	lbi_ans_t          ans;
	lbi_int_t          ia;
	logic              stall;
	logic              fault;
	int                bad_count = 0;
	int                total_checks = 0;
	int                n;
	int                k;
	lbi_kind_t         kt[5] = '{K_MRD, K_FETCH, K_MWR, K_IORD, K_IOWR};
	logic [23:0]       at[5] = '{24'h9a_bc01, 24'h12_3456, 24'h40_0010, 24'h77_1234, 24'h56_8a1f};

	always #4 clk = ~clk;

	lbi_bus_unit #(
		.P_INIT_SYS_CYC(4)
	) DUT (
		.i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1), .i_reset(rst_pin),
		.i_ready_n(ready_n), .i_hold(hold), .i_maskable_irq(irq), .i_nmi(nmi),
		.i_coproc_operand_request(preq), .i_busy_n(busy_n), .i_error_n(err_n),
		.i_data(data), .o_pins(pins), .i_req_valid(req_valid), .i_req(req),
		.i_pe_req(pe_req), .i_insn_end(insn_end), .i_coproc_wait_insn(wait_insn),
		.o_ans(ans), .o_int(ia), .o_stall(stall), .o_coproc_fault(fault),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_we(reg_we),
		.i_reg_re(reg_re), .o_reg_rdata(reg_rdata)
	);

	lbi_far_side u_far (
		.i_clk(clk), .i_arst_n(arst_n), .i_pins(pins), .i_wait(wt),
		.o_ready_n(ready_n), .o_data(data)
	);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task report_and_stop;
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	function automatic logic hit(input int s);
		case (s)
			0: hit = ans.boot;
			1: hit = pins.hold_grant;
			2: hit = !pins.hold_grant;
			4: hit = ans.done;
			default: hit = !pins.coproc_operand_ack_n;
		endcase
	endfunction

	// bounded wait on one of the completion flags above
	task automatic wfor(input int s);
		n = 0;
		@(negedge clk);
		while (hit(s) !== 1'b1 && n < 300) begin
			n++;
			@(negedge clk);
		end
		chk(hit(s), 1'b1);
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask

	task automatic bus(input lbi_kind_t kd, input logic [23:0] a, input logic w,
			input logic [3:0] ws, input logic lk);
		logic       io;
		logic [7:0] b;
		io = (kd == K_IORD || kd == K_IOWR);
		b = a[7:0];
		@(posedge clk);
		wt <= ws;
		req <= '{kd, a, w, 1'b0, 1'b0, 1'b0, 16'hc3a5};
		req_valid <= 1'b1;
		n = 0;
		@(negedge clk);
		while (pins.bus_status_hi_n & pins.bus_status_lo_n && n < 300) begin
			n++;
			@(negedge clk);
		end
		chk(pins.addr[23:1], {io ? 8'h00 : a[23:16], a[15:1]});
		chk({pins.upper_byte_enable_n, pins.addr[0]}, w ? 2'b00 : {~a[0], a[0]});
		chk({pins.mem_io, pins.code_or_int_ack, pins.lock_n}, {!io, io || kd == K_FETCH, !lk});
		if (kd == K_MWR || kd == K_IOWR) begin
			chk({pins.data_oe, pins.data}, {1'b1, w ? 16'hc3a5 : 16'ha5a5});
		end
		n = 0;
		@(negedge clk);
		while (!ans.done && n < 300) begin
			n++;
			@(negedge clk);
		end
		// ready is only looked at on phase-one edges, so waits count in pairs
		chk(n, 3 + 2 * (ws / 2));
		if (kd != K_MWR && kd != K_IOWR) begin
			chk(w ? ans.rdata : {8'h00, ans.rdata[7:0]},
				w ? {b ^ 8'ha5, b ^ 8'h3c} : {8'h00, a[0] ? b ^ 8'ha5 : b ^ 8'h3c});
		end
		@(posedge clk);
		req_valid <= 1'b0;
	endtask

	task automatic pulse;
		@(posedge clk);
		insn_end <= 1'b1;
		@(posedge clk);
		insn_end <= 1'b0;
	endtask

	// raise a request, then count acknowledge cycles and catch the take pulse
	task automatic maskable_irq(input logic ie, input logic nm, input int ea, input logic et,
			input logic [7:0] ev);
		logic       pv;
		logic       tk;
		logic [7:0] v;
		pv = 1'b0;
		tk = 1'b0;
		v = 8'h00;
		wr(REG_CTRL, {7'h00, ie});
		@(posedge clk);
		wt <= 4'h0;
		irq <= !nm;
		nmi <= nm;
		repeat (8) @(posedge clk);
		pulse();
		k = 0;
		repeat (60) begin
			@(negedge clk);
			k += int'(!(pins.bus_status_hi_n | pins.bus_status_lo_n) && !pv);
			pv = !(pins.bus_status_hi_n | pins.bus_status_lo_n);
			if (ia.take === 1'b1 && !tk) begin
				tk = 1'b1;
				v = ia.vector;
			end
		end
		chk(k, ea);
		chk(tk, et);
		chk(v, et ? ev : 8'h00);
		@(posedge clk);
		irq <= 1'b0;
		nmi <= 1'b0;
	endtask

	initial begin
		#400000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		wfor(0);
		rd(REG_CTRL, CTRL_RST);
		wr(2'h3, 8'hff);
		rd(2'h3, 8'h00);
		wr(REG_CTRL, 8'hff);
		rd(REG_CTRL, CTRL_MASK);
		for (k = 0; k < 5; k++) begin
			bus(kt[k], at[k], k == 1 || k == 2, 4'(k), k < 2);
		end
		rd(REG_CTRL, 8'h01);
		@(posedge clk);
		hold <= 1'b1;
		wfor(1);
		req <= '{K_MRD, 24'h00_0100, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000};
		req_valid <= 1'b1;
		k = 0;
		repeat (30) begin
			@(negedge clk);
			k += int'(ans.done === 1'b1);
		end
		chk(k, 0);
		@(posedge clk);
		hold <= 1'b0;
		wfor(2);
		wfor(4);
		@(posedge clk);
		req_valid <= 1'b0;
		maskable_irq(1'b1, 1'b0, 2, 1'b1, 8'h3c);
		maskable_irq(1'b0, 1'b0, 0, 1'b0, 8'h00);
		maskable_irq(1'b0, 1'b1, 0, 1'b1, NMI_VECTOR);
		@(posedge clk);
		wait_insn <= 1'b1;
		busy_n <= 1'b0;
		repeat (8) @(negedge clk);
		chk({stall, fault}, 2'b10);
		@(posedge clk);
		err_n <= 1'b0;
		repeat (8) @(negedge clk);
		chk({stall, fault}, 2'b11);
		@(posedge clk);
		busy_n <= 1'b1;
		err_n <= 1'b1;
		wait_insn <= 1'b0;
		repeat (8) @(negedge clk);
		chk({stall, fault}, 2'b00);
		@(posedge clk);
		pe_req <= '{K_MRD, 24'h00_0200, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000};
		preq <= 1'b1;
		wfor(5);
		@(posedge clk);
		preq <= 1'b0;
		repeat (20) @(posedge clk);
		wr(REG_CTRL, 8'h01);
		@(posedge clk);
		rst_pin <= 1'b1;
		repeat (20) @(negedge clk);
		chk({pins.addr, pins.data_oe, pins.hold_grant, pins.mem_io}, {24'hff_ffff, 3'b000});
		@(posedge clk);
		rst_pin <= 1'b0;
		wfor(0);
		rd(REG_CTRL, CTRL_RST);
		report_and_stop();
	end
endmodule
